// ==== gctrl_map.svh ====
// Register offsets, field positions, reset values and timing for the global control bank
`ifndef GCTRL_MAP_SVH
`define GCTRL_MAP_SVH
`define OFS_TEST_A 8'h09
`define OFS_TEST_B 8'h0a
`define OFS_CLKIND 8'h0b
`define OFS_TAGPAUSE 8'h0c
`define OFS_TEST_C 8'h0d
`define OFS_POWER 8'h0e
`define OFS_SLEEP 8'h0f
`define RST_TEST_A 8'h40
`define RST_TEST_B 8'h00
`define RST_TEST_C 8'h00
`define RST_TAGPAUSE_HI 8'h44
`define RST_SLEEP 8'h50
`define BIT_EDGE 6
`define BIT_MODE_HI 5
`define BIT_MODE_LO 4
`define BIT_REFEN 1
`define BIT_SPIEDGE 0
`define BIT_TAIL 1
`define BIT_PAUSE 0
`define BIT_PLLPD 5
`define BIT_PM_HI 4
`define BIT_PM_LO 3
`define SLEEP_UNIT_MS 20
`define CLK_MHZ 100
`define BLINK_HALF 24'h3d0900
`define REF_DIV 2'h1
`define WMASK_CLKIND 8'h73
`define IND_ALL_OFF 5'h1f
`endif

// ==== gctrl_pkg.sv ====
// Types shared by the global control bank
package gctrl_pkg;
  typedef enum logic [1:0] {IND_LINK, IND_ACT, IND_LINKACT, IND_SPEED} ind_mode_t;
  typedef enum logic [1:0] {PM_NORMAL, PM_ENERGY, PM_SOFTDOWN, PM_RSVD} pm_mode_t;
  typedef struct packed {
    logic link;
    logic act;
    logic speed100;
    logic full_duplex;
  } port_status_t;
  typedef struct packed {
    logic uplink_fall_edge;
    logic spi_rise_edge;
    logic tail_tag_en;
    logic pass_pause;
    logic pll_pd_en;
    pm_mode_t pm_mode;
  } ctrl_out_t;
endpackage

// ==== gctrl_regs.sv ====
// Global control and power register bank with Wishbone slave
`include "gctrl_map.svh"
// Overview of operation
// - Control bit 6 at 0x0b picks falling (1) or rising (0) uplink sampling edge
// - Two-bit field chooses indicator mode; indicator outputs light when driven low
// - Link lit on link, activity blinks on traffic, combined does both
// - Speed mode lit at 100 dark at 10
// - Bit 1 at 0x0b enables the 25 MHz reference clock output
// - Reference enable loads from indicator strap at reset; pull-up enables it
// - Bit 0 at 0x0b picks read data edge; host samples to match
// - Tail tag bit asks uplink frames for one byte before the FCS
// - Pass-pause bit forwards flow-control frames, clear filters them
// - PLL power-down bit acts only in energy-detect mode
// - Power mode: 00 normal, 01 energy detect, 10 soft power-down, 11 reserved
// - Energy-detect sleep after delay value times 20 ms without energy
// - Sleep delay is eight bits, resets to 80 decimal
module gctrl_regs #(
  parameter int unsigned MS_CYCLES = `CLK_MHZ * 1000
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Strap pin and per-port status
  input wire logic STRAP_PIN_I,
  input wire gctrl_pkg::port_status_t [4:0] PORT_STATUS_I,
  input wire logic ENERGY_I,
  // Indicators and steering outputs
  output logic [4:0] IND_N_O,
  output logic REF_CLOCK_OUTPUT_O,
  output gctrl_pkg::ctrl_out_t CTRL_O,
  output logic PLL_POWERDOWN_O,
  output logic LOW_POWER_O
);
  logic strap_m_q, strap_s_q, energy_m_q, energy_s_q;
  logic [4:0][3:0] st_m_q, st_s_q;
  logic seen_q;
  logic [7:0] clkind_q, clkind_d;
  logic [1:0] tagp_q, tagp_d;
  logic pllpd_q, pllpd_d;
  gctrl_pkg::pm_mode_t pm_q, pm_d;
  logic [7:0] sleep_q, sleep_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [23:0] blink_q, blink_d;
  logic blink_ph_q, blink_ph_d;
  logic [1:0] div_q, div_d;
  logic ref_q, ref_d;
  logic [4:0] ind_n_q, ind_n_d;
  logic asleep;
  logic req, wr, rd;

  // Decode a byte register readback
  function automatic logic [7:0] read_reg(input logic [7:0] adr, input logic [7:0] ci, input logic [1:0] tp,
                                          input logic pd, input logic [1:0] pm, input logic [7:0] sl);
    logic [7:0] v;
    v = 8'h00;
    case (adr)
      `OFS_TEST_A: v = `RST_TEST_A;
      `OFS_TEST_B: v = `RST_TEST_B;
      `OFS_CLKIND: v = ci;
      `OFS_TAGPAUSE: v = `RST_TAGPAUSE_HI | {6'h00, tp};
      `OFS_TEST_C: v = `RST_TEST_C;
      `OFS_POWER: v = {2'h0, pd, pm, 3'h0};
      `OFS_SLEEP: v = sl;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge MCLK_I) begin
    strap_m_q <= STRAP_PIN_I;
    strap_s_q <= strap_m_q;
    energy_m_q <= ENERGY_I;
    energy_s_q <= energy_m_q;
    for (int p = 0; p < 5; p++) begin
      st_m_q[p] <= PORT_STATUS_I[p];
      st_s_q[p] <= st_m_q[p];
    end
  end

  assign req = CYC_I && STB_I && !ack_q;
  assign wr = req && WE_I && SEL_I[0];
  assign rd = req && !WE_I;

  // Register next-state: writes touch only writable bits
  always_comb begin
    clkind_d = clkind_q;
    tagp_d = tagp_q;
    pllpd_d = pllpd_q;
    pm_d = pm_q;
    sleep_d = sleep_q;
    ack_d = req;
    rdata_d = rdata_q;
    if (!seen_q) begin
      clkind_d[`BIT_REFEN] = strap_s_q;
    end
    if (rd) begin
      rdata_d = {24'h000000, read_reg(ADR_I, clkind_q, tagp_q, pllpd_q, pm_q, sleep_q)};
      if (ADR_I == `OFS_POWER) begin
        pm_d = gctrl_pkg::PM_NORMAL;
      end
    end
    if (wr) begin
      case (ADR_I)
        `OFS_CLKIND: begin
          clkind_d = DAT_I[7:0] & `WMASK_CLKIND;
        end
        `OFS_TAGPAUSE: begin
          tagp_d = DAT_I[1:0];
        end
        `OFS_POWER: begin
          pllpd_d = DAT_I[`BIT_PLLPD];
          pm_d = gctrl_pkg::pm_mode_t'(DAT_I[`BIT_PM_HI:`BIT_PM_LO]);
        end
        `OFS_SLEEP: begin
          sleep_d = DAT_I[7:0];
        end
        default: begin
          sleep_d = sleep_q;
        end
      endcase
    end
  end

  // Register bank storage; strap captured on first cycle after reset release
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      seen_q <= 1'b0;
      clkind_q <= 8'h00;
      tagp_q <= 2'h0;
      pllpd_q <= 1'b0;
      pm_q <= gctrl_pkg::PM_NORMAL;
      sleep_q <= `RST_SLEEP;
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      seen_q <= 1'b1;
      clkind_q <= clkind_d;
      tagp_q <= tagp_d;
      pllpd_q <= pllpd_d;
      pm_q <= pm_d;
      sleep_q <= sleep_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = rdata_q;

  // Blink timebase and 25 MHz divider (divide 100 MHz by four)
  always_comb begin
    blink_d = blink_q + 24'h1;
    blink_ph_d = blink_ph_q;
    if (blink_q == `BLINK_HALF) begin
      blink_d = 24'h0;
      blink_ph_d = !blink_ph_q;
    end
    div_d = div_q + 2'h1;
    ref_d = 1'b0;
    if (clkind_q[`BIT_REFEN]) begin
      ref_d = (div_q == `REF_DIV) ? !ref_q : ref_q;
      if (div_q == `REF_DIV) begin
        div_d = 2'h0;
      end
    end
  end

  // Indicator decode per port; low lights the lamp
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      logic lit;
      lit = 1'b0;
      case (gctrl_pkg::ind_mode_t'(clkind_q[`BIT_MODE_HI:`BIT_MODE_LO]))
        gctrl_pkg::IND_LINK: lit = st_s_q[p][3];
        gctrl_pkg::IND_ACT: lit = st_s_q[p][2] && blink_ph_q;
        gctrl_pkg::IND_LINKACT: lit = st_s_q[p][3] && !(st_s_q[p][2] && blink_ph_q);
        gctrl_pkg::IND_SPEED: lit = st_s_q[p][1];
        default: lit = st_s_q[p][0];
      endcase
      ind_n_d[p] = !lit;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      blink_q <= 24'h0;
      blink_ph_q <= 1'b0;
      div_q <= 2'h0;
      ref_q <= 1'b0;
      ind_n_q <= `IND_ALL_OFF;
    end else begin
      blink_q <= blink_d;
      blink_ph_q <= blink_ph_d;
      div_q <= div_d;
      ref_q <= ref_d;
      ind_n_q <= ind_n_d;
    end
  end

  assign IND_N_O = ind_n_q;
  assign REF_CLOCK_OUTPUT_O = ref_q;

  // Steering outputs
  assign CTRL_O.uplink_fall_edge = clkind_q[`BIT_EDGE];
  assign CTRL_O.spi_rise_edge = clkind_q[`BIT_SPIEDGE];
  assign CTRL_O.tail_tag_en = tagp_q[`BIT_TAIL];
  assign CTRL_O.pass_pause = tagp_q[`BIT_PAUSE];
  assign CTRL_O.pll_pd_en = pllpd_q;
  assign CTRL_O.pm_mode = pm_q;
  // PLL may only drop once energy-detect sleep is reached
  assign PLL_POWERDOWN_O = pllpd_q && (pm_q == gctrl_pkg::PM_ENERGY) && asleep;
  assign LOW_POWER_O = asleep || (pm_q == gctrl_pkg::PM_SOFTDOWN);

  gctrl_sleep_timer #(.MS_CYCLES(MS_CYCLES)) u_sleep (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .enable_i(pm_q == gctrl_pkg::PM_ENERGY),
    .energy_i(energy_s_q),
    .delay_i(sleep_q),
    .asleep_o(asleep)
  );

  // Bus handshake pieces: a taken request and its single-cycle answer
  sequence s_bus_request;
    CYC_I && STB_I && !ACK_O;
  endsequence

  sequence s_ack_pulse;
    ACK_O ##1 !ACK_O;
  endsequence

  // Register accesses that the checks below key on
  sequence s_read_power;
    rd && ADR_I == `OFS_POWER;
  endsequence

  sequence s_write_clkind;
    wr && ADR_I == `OFS_CLKIND;
  endsequence

  sequence s_write_tagpause;
    wr && ADR_I == `OFS_TAGPAUSE;
  endsequence

  sequence s_write_sleep;
    wr && ADR_I == `OFS_SLEEP;
  endsequence

  // A rise of the reference clock is followed by a fall two cycles on, unless it was switched off
  sequence s_ref_fall_or_off;
    ##2 ($fell(ref_q) || !clkind_q[`BIT_REFEN]);
  endsequence

  // Bus answer: a master that drops stb late would see a second ack otherwise
  a_ack_one_cycle: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    s_bus_request |=> s_ack_pulse) else $error("Ack not single-cycle");

  // Read side effects and fixed readback
  a_pm_read_clear: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    s_read_power |=> pm_q == gctrl_pkg::PM_NORMAL) else $error("Power mode not cleared");
  a_test_a_fixed: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    rd && ADR_I == `OFS_TEST_A |=> DAT_O == {24'h000000, `RST_TEST_A}) else $error("Test A readback wrong");
  a_test_c_fixed: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    rd && ADR_I == `OFS_TEST_C |=> DAT_O == {24'h000000, `RST_TEST_C}) else $error("Test C readback wrong");

  // Write paths keep only the writable bits; sleep delay reset value and strap load
  a_reserved_zero: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (clkind_q & ~`WMASK_CLKIND) == 8'h00) else $error("Reserved bits set");
  a_clkind_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    s_write_clkind |=> clkind_q == ($past(DAT_I[7:0]) & `WMASK_CLKIND)) else $error("Clock config write lost");
  a_tagpause_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    s_write_tagpause |=> tagp_q == $past(DAT_I[1:0])) else $error("Tag and pause write lost");
  a_sleep_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    s_write_sleep |=> sleep_q == $past(DAT_I[7:0])) else $error("Sleep delay write lost");
  a_sleep_reset: assert property (@(posedge MCLK_I)
    SRST_I |=> sleep_q == `RST_SLEEP) else $error("Sleep delay reset wrong");
  a_strap_load: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !seen_q && !SRST_I && !wr |=> clkind_q[`BIT_REFEN] == $past(strap_s_q)) else $error("Strap not loaded");

  // Power and clock outputs
  a_pll_gate: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    PLL_POWERDOWN_O |-> pm_q == gctrl_pkg::PM_ENERGY) else $error("PLL down outside energy mode");
  a_ref_off: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !clkind_q[`BIT_REFEN] |=> !REF_CLOCK_OUTPUT_O) else $error("Ref clock while disabled");
  a_ref_toggle: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    clkind_q[`BIT_REFEN] && $rose(ref_q) |-> s_ref_fall_or_off) else $error("Ref clock not 25 MHz");

  // Indicators follow the synchronised status one register later
  a_ind_link: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    clkind_q[`BIT_MODE_HI:`BIT_MODE_LO] == gctrl_pkg::IND_LINK && $stable(clkind_q)
    |=> IND_N_O[0] == !$past(st_s_q[0][3])) else $error("Link indicator wrong");
  a_ind_speed: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    clkind_q[`BIT_MODE_HI:`BIT_MODE_LO] == gctrl_pkg::IND_SPEED && $stable(clkind_q)
    |=> IND_N_O[1] == !$past(st_s_q[1][1])) else $error("Speed indicator wrong");
endmodule // gctrl_regs

// ==== gctrl_sleep_timer.sv ====
// Energy-detect sleep timer: counts no-energy time in 20 ms units
`include "gctrl_map.svh"
module gctrl_sleep_timer #(
  parameter int unsigned MS_CYCLES = `CLK_MHZ * 1000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic energy_i,
  input wire logic [7:0] delay_i,
  output logic asleep_o
);
  localparam int unsigned UNIT_CYCLES = MS_CYCLES * `SLEEP_UNIT_MS;
  logic [31:0] tick_q, tick_d;
  logic [7:0] units_q, units_d;
  logic asleep_q, asleep_d;

  // Any energy or leaving the mode restarts the wait
  always_comb begin
    tick_d = tick_q;
    units_d = units_q;
    asleep_d = asleep_q;
    if (!enable_i || energy_i) begin
      tick_d = 32'h0;
      units_d = 8'h00;
      asleep_d = 1'b0;
    end else if (!asleep_q) begin
      if (units_q >= delay_i) begin
        asleep_d = 1'b1;
      end else if (tick_q == UNIT_CYCLES - 1) begin
        tick_d = 32'h0;
        units_d = units_q + 8'h01;
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= 32'h0;
      units_q <= 8'h00;
      asleep_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      units_q <= units_d;
      asleep_q <= asleep_d;
    end
  end
  assign asleep_o = asleep_q;

  a_sleep_needs_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    energy_i |=> !asleep_q) else $error("Sleep entered despite energy");
endmodule // gctrl_sleep_timer

// ==== host_model.sv ====
// Wishbone host model issuing single classic cycles
module host_model (
  // Clock
  input wire logic clk_i,
  // Slave answer
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // Request held until ack is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= {24'h0, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released data keeps moving so a stale value cannot pass
    dat_o <= ~dat_o;
  endtask
endmodule // host_model

// ==== tb_top.sv ====
// Self-checking bench for the global control bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we, ack, strap, energy, refo, pllpd, lowp;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  logic [4:0] ind_n;
  gctrl_pkg::port_status_t [4:0] status;
  gctrl_pkg::ctrl_out_t ctrl;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [7:0] ro_a [3] = '{8'h09, 8'h0a, 8'h0d};
  logic [7:0] ro_e [3] = '{8'h40, 8'h00, 8'h00};
  // Short ms count keeps the sleep test brief
  gctrl_regs #(.MS_CYCLES(10)) DUT (.MCLK_I(clk), .SRST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dw), .DAT_O(dr), .ACK_O(ack), .STRAP_PIN_I(strap),
    .PORT_STATUS_I(status), .ENERGY_I(energy), .IND_N_O(ind_n), .REF_CLOCK_OUTPUT_O(refo),
    .CTRL_O(ctrl), .PLL_POWERDOWN_O(pllpd), .LOW_POWER_O(lowp));
  host_model host (.clk_i(clk), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dw));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // Toggles of the reference output over 40 cycles
  task automatic cnt_ref(output int c);
    logic p;
    c = 0;
    // Start one edge late so a change launched by the last write is not counted
    @(posedge clk);
    p = refo;
    repeat (40) begin
      @(posedge clk);
      if (refo !== p) c++;
      p = refo;
    end
  endtask
  // Strap is set well ahead of the release
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    status <= '0;
    energy <= 1'b0;
    strap <= 1'b1;
    reset_dut();
    rdc(8'h0b, 8'h02);
    rdc(8'h0c, 8'h44);
    rdc(8'h0e, 8'h00);
    rdc(8'h0f, 8'h50);
    rdc(8'h20, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rdc(ro_a[i], ro_e[i]);
      wr(ro_a[i], 8'hff);
      rdc(ro_a[i], ro_e[i]);
    end
    $display("test reset and read-only done");
    wr(8'h0b, 8'hff);
    rdc(8'h0b, 8'h73);
    chk(ctrl.uplink_fall_edge, 1'b1);
    chk(ctrl.spi_rise_edge, 1'b1);
    cnt_ref(n);
    chk(8'(n >= 19 && n <= 21), 8'h01);
    wr(8'h0b, 8'h00);
    chk(ctrl.uplink_fall_edge, 1'b0);
    chk(ctrl.spi_rise_edge, 1'b0);
    cnt_ref(n);
    chk(8'(n), 8'h00);
    wr(8'h0c, 8'hff);
    rdc(8'h0c, 8'h47);
    chk({ctrl.tail_tag_en, ctrl.pass_pause}, 8'h03);
    wr(8'h0c, 8'h00);
    chk({ctrl.tail_tag_en, ctrl.pass_pause}, 8'h00);
    $display("test config bits done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h0e, 8'(m << 3));
      chk(ctrl.pm_mode, 8'(m));
      chk(lowp, 8'(m == 2));
    end
    rdc(8'h0e, 8'h10);
    rdc(8'h0e, 8'h00);
    // Delay 2 units of 20 ms is 400 cycles here
    wr(8'h0f, 8'h02);
    wr(8'h0e, 8'h28);
    repeat (300) @(posedge clk);
    chk({pllpd, lowp}, 8'h00);
    repeat (200) @(posedge clk);
    chk({pllpd, lowp}, 8'h03);
    // Energy wakes the block after two sync stages and one timer register
    energy <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pllpd, lowp}, 8'h00);
    energy <= 1'b0;
    wr(8'h0e, 8'h08);
    chk(pllpd, 1'b0);
    wr(8'h0e, 8'h20);
    chk({ctrl.pll_pd_en, pllpd}, 8'h02);
    $display("test power done");
    wr(8'h0e, 8'h00);
    status[0].link <= 1'b1;
    status[1].speed100 <= 1'b1;
    wr(8'h0b, 8'h00);
    repeat (6) @(posedge clk);
    chk(ind_n, 5'h1e);
    wr(8'h0b, 8'h30);
    repeat (6) @(posedge clk);
    chk(ind_n, 5'h1d);
    status[2].link <= 1'b1;
    status[2].act <= 1'b1;
    // Blink starts in its dark half after reset, and one half outlasts this bench
    wr(8'h0b, 8'h10);
    repeat (6) @(posedge clk);
    chk(ind_n, 5'h1f);
    wr(8'h0b, 8'h20);
    repeat (6) @(posedge clk);
    chk(ind_n, 5'h1a);
    $display("test indicators done");
    strap <= 1'b0;
    reset_dut();
    rdc(8'h0b, 8'h00);
    $display("test strap done");
    conclude();
  end
endmodule // tb_top
